/* File: rtl/rxirq_consts.vh */
// Overview of operation
// - Low enable bit 6: line length change
// - Low enable bit 5: line count change
// - Low enable bit 4: receive buffer overflow
// - Low enable bit 2: link parity error
// - Low enable bit 1: port valid change
// - Low enable bit 0: lock status change
// - High flag 2: encoding error, second-status-read clears
// - High flag 1: sequence error, first-status-read clears
// - High flag 0: control CRC error, first-read clears
// - Low flag 6: line length, second-read clears
// - Low flag 5: line count, second-read clears
// - Low flag 4: buffer overflow, second-read clears
// - Low flag 2: parity error, first-read clears
// - Low flag 1: port valid, first-read clears
// - Low flag 0: lock change, first-read clears
// - GPIO flags bits 7:4, cleared on read
// - Live forward GPIO levels in bits 3:0
// - Port select routes per-port register accesses
// - High enable bits 2:0 for link errors
`ifndef RXIRQ_CONSTS_VH
`define RXIRQ_CONSTS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define RXIRQ_PORTS 4
`define RXIRQ_SEL_W 2
`define RXIRQ_DATA_W 8
`define RXIRQ_GPIO_PER_PORT 4

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RXIRQ_ADDR_PORT_SEL 8'h4c
`define RXIRQ_ADDR_STATUS_FIRST 8'h4d
`define RXIRQ_ADDR_STATUS_SECOND 8'h4e
`define RXIRQ_ADDR_EN_HIGH 8'hd8
`define RXIRQ_ADDR_EN_LOW 8'hd9
`define RXIRQ_ADDR_ST_HIGH 8'hda
`define RXIRQ_ADDR_ST_LOW 8'hdb
`define RXIRQ_ADDR_GPIO_ST 8'hdc

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define RXIRQ_BIT_LINE_LEN 6
`define RXIRQ_BIT_LINE_CNT 5
`define RXIRQ_BIT_BUF_OVF 4
`define RXIRQ_BIT_PARITY 2
`define RXIRQ_BIT_PORT_VALID 1
`define RXIRQ_BIT_LOCK 0
`define RXIRQ_BIT_ENC_ERR 2
`define RXIRQ_BIT_SEQ_ERR 1
`define RXIRQ_BIT_CRC_ERR 0
`define RXIRQ_MASK_LOW 8'h77
`define RXIRQ_MASK_HIGH 8'h07
`define RXIRQ_MASK_SEL 8'h03
`define RXIRQ_MASK_FIRST_LOW 8'h07
`define RXIRQ_MASK_SECOND_LOW 8'h70
`define RXIRQ_MASK_FIRST_HIGH 8'h03
`define RXIRQ_MASK_SECOND_HIGH 8'h04
`define RXIRQ_RESET_BYTE 8'h00

`endif

/* File: rtl/rxirq_sync.v */
`timescale 1ns/1ps
`include "rxirq_consts.vh"

module rxirq_sync #(
    parameter WIDTH = 16
) (
    input wire clock, // System clock
    input wire arst_n, // Async reset, active low
    input wire [WIDTH-1:0] async_in, // Levels from outside the domain
    output reg [WIDTH-1:0] sync_out // Two-flop synchronised levels
);

// ----------------------------------------
// Two-flop synchroniser
// ----------------------------------------
reg [WIDTH-1:0] meta_reg;

// First stage feeds only the second stage
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        meta_reg <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end else begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end
end

endmodule

/* File: rtl/rxirq_top.v */
`timescale 1ns/1ps
`include "rxirq_consts.vh"

module rxirq_top (
    input wire clock, // 100 MHz system clock
    input wire arst_n, // Async reset, active low
    input wire reg_wr, // Register write strobe, one cycle
    input wire reg_rd, // Register read strobe, one cycle
    input wire [7:0] reg_addr, // Register address
    input wire [7:0] reg_wdata, // Register write data
    output reg [7:0] reg_rdata, // Read data, valid with reg_rvalid
    output reg reg_rvalid, // Read answer pulse
    output reg irq, // Combined interrupt request
    input wire [3:0] ev_line_length_change, // Per-port event pulses
    input wire [3:0] ev_line_count_change, // Per-port event pulses
    input wire [3:0] ev_buffer_overflow, // Per-port event pulses
    input wire [3:0] ev_link_parity, // Per-port event pulses
    input wire [3:0] ev_port_valid_change, // Per-port event pulses
    input wire [3:0] ev_lock_change, // Per-port event pulses
    input wire [3:0] ev_encoding_error, // Per-port event pulses
    input wire [3:0] ev_control_channel_sequence, // Per-port event pulses
    input wire [3:0] ev_control_channel_crc, // Per-port event pulses
    input wire [15:0] ev_gpio_irq, // GPIO conditions, port*4+gpio
    input wire [15:0] forward_gpio_level // Async GPIO levels, port*4+gpio
);

// ----------------------------------------
// Port select and access decode
// ----------------------------------------
reg [`RXIRQ_SEL_W-1:0] port_sel_reg;
wire [15:0] gpio_level_sync;
wire [31:0] en_low_flat;
wire [31:0] en_high_flat;
wire [31:0] st_low_flat;
wire [31:0] st_high_flat;
wire [31:0] gpio_st_flat;
wire [3:0] port_irq;
wire [4:0] byte_base;

// Index of the selected port's byte in each flat vector
assign byte_base = {port_sel_reg, 3'b000};

// Port select register; only the low bits are kept
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        port_sel_reg <= {`RXIRQ_SEL_W{1'b0}};
    end else if (reg_wr && reg_addr == `RXIRQ_ADDR_PORT_SEL) begin
        port_sel_reg <= reg_wdata[`RXIRQ_SEL_W-1:0];
    end
end

// GPIO levels come from the link side, so resynchronise them
rxirq_sync #(
    .WIDTH(16)
) u_gpio_sync (
    .clock(clock),
    .arst_n(arst_n),
    .async_in(forward_gpio_level),
    .sync_out(gpio_level_sync)
);

// ----------------------------------------
// Per-port enables and sticky flags
// ----------------------------------------
genvar p;
generate
    for (p = 0; p < `RXIRQ_PORTS; p = p + 1) begin : g_port
        reg [7:0] en_low_reg;
        reg [7:0] en_high_reg;
        reg [7:0] st_low_reg;
        reg [7:0] st_high_reg;
        reg [3:0] gpio_flag_reg;
        reg [7:0] ev_low;
        reg [7:0] ev_high;
        wire hit;
        wire rd_first;
        wire rd_second;
        wire rd_gpio;
        reg [7:0] clr_low;
        reg [7:0] clr_high;

        // Port index at select width, so the compare has no silent extension
        localparam [`RXIRQ_SEL_W-1:0] PORT_ID = p;

        // Accesses reach this port only while it is selected
        assign hit = (port_sel_reg == PORT_ID);
        assign rd_first = reg_rd && hit && reg_addr == `RXIRQ_ADDR_STATUS_FIRST;
        assign rd_second = reg_rd && hit && reg_addr == `RXIRQ_ADDR_STATUS_SECOND;
        assign rd_gpio = reg_rd && hit && reg_addr == `RXIRQ_ADDR_GPIO_ST;

        // Gather this port's events into register bit positions
        always @* begin
            ev_low = `RXIRQ_RESET_BYTE;
            ev_high = `RXIRQ_RESET_BYTE;
            ev_low[`RXIRQ_BIT_LINE_LEN] = ev_line_length_change[p];
            ev_low[`RXIRQ_BIT_LINE_CNT] = ev_line_count_change[p];
            ev_low[`RXIRQ_BIT_BUF_OVF] = ev_buffer_overflow[p];
            ev_low[`RXIRQ_BIT_PARITY] = ev_link_parity[p];
            ev_low[`RXIRQ_BIT_PORT_VALID] = ev_port_valid_change[p];
            ev_low[`RXIRQ_BIT_LOCK] = ev_lock_change[p];
            ev_high[`RXIRQ_BIT_ENC_ERR] = ev_encoding_error[p];
            ev_high[`RXIRQ_BIT_SEQ_ERR] = ev_control_channel_sequence[p];
            ev_high[`RXIRQ_BIT_CRC_ERR] = ev_control_channel_crc[p];
        end

        // Which flags each status read clears
        always @* begin
            clr_low = `RXIRQ_RESET_BYTE;
            clr_high = `RXIRQ_RESET_BYTE;
            if (rd_first) begin
                clr_low = clr_low | `RXIRQ_MASK_FIRST_LOW;
                clr_high = clr_high | `RXIRQ_MASK_FIRST_HIGH;
            end
            if (rd_second) begin
                clr_low = clr_low | `RXIRQ_MASK_SECOND_LOW;
                clr_high = clr_high | `RXIRQ_MASK_SECOND_HIGH;
            end
        end

        // Enable registers, reserved bits masked on write
        always @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                en_low_reg <= `RXIRQ_RESET_BYTE;
                en_high_reg <= `RXIRQ_RESET_BYTE;
            end else begin
                if (reg_wr && hit && reg_addr == `RXIRQ_ADDR_EN_LOW) begin
                    en_low_reg <= reg_wdata & `RXIRQ_MASK_LOW;
                end
                if (reg_wr && hit && reg_addr == `RXIRQ_ADDR_EN_HIGH) begin
                    en_high_reg <= reg_wdata & `RXIRQ_MASK_HIGH;
                end
            end
        end

        // Sticky flags; a new event wins over a same-cycle clear
        always @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                st_low_reg <= `RXIRQ_RESET_BYTE;
                st_high_reg <= `RXIRQ_RESET_BYTE;
            end else begin
                st_low_reg <= ((st_low_reg & ~clr_low) | ev_low) & `RXIRQ_MASK_LOW;
                st_high_reg <= ((st_high_reg & ~clr_high) | ev_high) & `RXIRQ_MASK_HIGH;
            end
        end

        // GPIO flags clear when their register is read
        always @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                gpio_flag_reg <= 4'h0;
            end else if (rd_gpio) begin
                gpio_flag_reg <= ev_gpio_irq[p*4 +: 4];
            end else begin
                gpio_flag_reg <= gpio_flag_reg | ev_gpio_irq[p*4 +: 4];
            end
        end

        // Flat views for readback, live levels in the low nibble
        assign en_low_flat[p*8 +: 8] = en_low_reg;
        assign en_high_flat[p*8 +: 8] = en_high_reg;
        assign st_low_flat[p*8 +: 8] = st_low_reg;
        assign st_high_flat[p*8 +: 8] = st_high_reg;
        assign gpio_st_flat[p*8 +: 8] = {gpio_flag_reg, gpio_level_sync[p*4 +: 4]};

        // Enabled flags of this port; GPIO flags raise the request with no enable gating
        assign port_irq[p] = |(st_low_reg & en_low_reg) |
                             |(st_high_reg & en_high_reg) |
                             |gpio_flag_reg;
    end
endgenerate

// ----------------------------------------
// Read data and interrupt output
// ----------------------------------------
reg [7:0] rdata_next;

// Readback mux; unmapped offsets and reserved bits return zero
always @* begin
    rdata_next = `RXIRQ_RESET_BYTE;
    case (reg_addr)
        `RXIRQ_ADDR_PORT_SEL: begin
            rdata_next = {6'h00, port_sel_reg};
        end
        `RXIRQ_ADDR_EN_HIGH: begin
            rdata_next = en_high_flat[byte_base +: 8];
        end
        `RXIRQ_ADDR_EN_LOW: begin
            rdata_next = en_low_flat[byte_base +: 8];
        end
        `RXIRQ_ADDR_ST_HIGH: begin
            rdata_next = st_high_flat[byte_base +: 8];
        end
        `RXIRQ_ADDR_ST_LOW: begin
            rdata_next = st_low_flat[byte_base +: 8];
        end
        `RXIRQ_ADDR_GPIO_ST: begin
            rdata_next = gpio_st_flat[byte_base +: 8];
        end
        default: begin
            rdata_next = `RXIRQ_RESET_BYTE;
        end
    endcase
end

// Registered answer; data holds until the next read
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        reg_rdata <= `RXIRQ_RESET_BYTE;
        reg_rvalid <= 1'b0;
    end else begin
        reg_rvalid <= reg_rd;
        if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end
end

// Level request, held while any enabled flag stands
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        irq <= 1'b0;
    end else begin
        irq <= |port_irq;
    end
end

endmodule

/* File: sim/rxirq_host.sv */
`timescale 1ns/1ps
// ----
// Host on the register bus
// ----
module rxirq_host (
    input wire logic clock, // Clock
    input wire logic reg_rvalid, // Read answer
    input wire logic [7:0] reg_rdata, // Read data
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [7:0] reg_addr, // Address
    output logic [7:0] reg_wdata // Write data
);
    // Idle bus at time zero
    initial begin
        reg_wr = 0;
        reg_rd = 0;
        reg_addr = 0;
        reg_wdata = 0;
    end
    // One-cycle strobe, changed off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clock);
        reg_wr = 0;
        reg_wdata = ~d;
    endtask
    // Answer is due one edge after the strobe; bounded wait
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clock);
        reg_rd = 0;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge clock);
        if (n == 4) begin
            tb.errors++;
            tb.test_done();
        end
        d = reg_rdata;
    endtask
endmodule

/* File: sim/rxirq_asserts.sv */
`timescale 1ns/1ps
// ----
// Port checks
// ----
module rxirq_asserts (
    input wire clock, // Clock
    input wire arst_n, // Reset, active low
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    input wire [7:0] reg_addr, // Address
    input wire [7:0] reg_rdata, // Read data
    input wire reg_rvalid, // Read answer
    input wire irq // Interrupt
);
    // One domain, so one default clock and disable
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    property p_ans; reg_rd |=> reg_rvalid; endproperty
    a_ans: assert property (p_ans) else $error("read unanswered");
    property p_noans; !reg_rd |=> !reg_rvalid; endproperty
    a_noans: assert property (p_noans) else $error("stray answer");
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap; reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not zero");
    property p_rlo; reg_rd && reg_addr[7:1] == 7'h6d |=> (reg_rdata & 8'h88) == 0; endproperty
    a_rlo: assert property (p_rlo) else $error("reserved low set");
    property p_rhi; reg_rd && reg_addr == 8'hd8 |=> reg_rdata[7:3] == 0; endproperty
    a_rhi: assert property (p_rhi) else $error("reserved high set");
    property p_sel; reg_rd && reg_addr == 8'h4c |=> reg_rdata[7:2] == 0; endproperty
    a_sel: assert property (p_sel) else $error("select wide");
    property p_fall; $fell(irq) |-> $past(reg_rd || reg_wr, 2); endproperty
    a_fall: assert property (p_fall) else $error("irq fell alone");
endmodule
bind rxirq_top rxirq_asserts rxirq_asserts_inst (.clock(clock), .arst_n(arst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .irq(irq));

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clock, arst_n, reg_wr, reg_rd, reg_rvalid, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, q;
    logic [3:0] ev [9];
    logic [15:0] gev, lvl;
    logic [7:0] ra [7] = '{8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'h4c, 8'h10};
    int errors, n_tests, p, k, b;
    // ----
    // Design and host
    // ----
    rxirq_top rxirq_top_inst (.clock(clock), .arst_n(arst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq(irq),
        .ev_line_length_change(ev[0]), .ev_line_count_change(ev[1]),
        .ev_buffer_overflow(ev[2]), .ev_link_parity(ev[3]),
        .ev_port_valid_change(ev[4]), .ev_lock_change(ev[5]),
        .ev_encoding_error(ev[6]), .ev_control_channel_sequence(ev[7]),
        .ev_control_channel_crc(ev[8]), .ev_gpio_irq(gev), .forward_gpio_level(lvl));
    rxirq_host h (.clock(clock), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    // Compare and verdict
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Event kind to bit, status and clearing address
    function automatic int bitpos(int k);
        return k < 3 ? 6 - k : (k < 6 ? 5 - k : 8 - k);
    endfunction
    function automatic logic [7:0] st_a(int k);
        return k < 6 ? 8'hdb : 8'hda;
    endfunction
    function automatic logic [7:0] clr_a(int k);
        return (k < 3 || k == 6) ? 8'h4e : 8'h4d;
    endfunction
    function automatic logic [7:0] gexp(logic [3:0] f, int p);
        return {f, lvl[p*4 +: 4]};
    endfunction
    // Free-running clock
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    // Main sequence
    initial begin
        arst_n = 0;
        lvl = 0;
        gev = 0;
        foreach (ev[i]) ev[i] = 0;
        d = 8'($urandom(32'h1fd1));
        repeat (3) @(negedge clock);
        arst_n = 1;
        h.wr(8'h10, 8'hff);
        foreach (ra[i]) begin
            h.rd(ra[i], q);
            chk(q, 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            h.wr(8'hd9, d);
            h.rd(8'hd9, q);
            chk(q, d & 8'h77);
            h.wr(8'hd8, d);
            h.rd(8'hd8, q);
            chk(q, d & 8'h07);
        end
        h.wr(8'hd9, 8'h00);
        h.wr(8'hd8, 8'h00);
        for (k = 0; k < 9; k++) begin
            p = $urandom % 4;
            b = bitpos(k);
            h.wr(8'h4c, 8'(p));
            h.wr(k < 6 ? 8'hd9 : 8'hd8, 8'h01 << b);
            @(negedge clock);
            ev[k][p] = 1;
            @(negedge clock);
            ev[k][p] = 0;
            repeat (2) @(negedge clock);
            chk({7'h0, irq}, 8'h01);
            h.rd(st_a(k), q);
            chk(q, 8'h01 << b);
            h.wr(8'h4c, 8'(p ^ 1));
            h.rd(st_a(k), q);
            chk(q, 8'h00);
            h.wr(8'h4c, 8'(p));
            h.rd(clr_a(k) ^ 8'h03, q);
            h.rd(st_a(k), q);
            chk(q, 8'h01 << b);
            h.rd(clr_a(k), q);
            repeat (2) @(negedge clock);
            chk({7'h0, irq}, 8'h00);
            h.rd(st_a(k), q);
            chk(q, 8'h00);
            h.wr(k < 6 ? 8'hd9 : 8'hd8, 8'h00);
            ev[k][p] = 1;
            @(negedge clock);
            ev[k][p] = 0;
            repeat (2) @(negedge clock);
            chk({7'h0, irq}, 8'h00);
            h.rd(st_a(k), q);
            chk(q, 8'h01 << b);
            // Event lands on the clearing read's edge: the flag must stay
            fork
                h.rd(clr_a(k), q);
                begin
                    @(negedge clock);
                    ev[k][p] = 1;
                    @(negedge clock);
                    ev[k][p] = 0;
                end
            join
            h.rd(st_a(k), q);
            chk(q, 8'h01 << b);
            h.rd(clr_a(k), q);
            h.rd(st_a(k), q);
            chk(q, 8'h00);
        end
        for (int g = 0; g < 4; g++) begin
            p = $urandom % 4;
            lvl = 16'($urandom);
            h.wr(8'h4c, 8'(p));
            gev = 16'h0001 << (p * 4 + g);
            @(negedge clock);
            gev = 0;
            repeat (2) @(negedge clock);
            chk({7'h0, irq}, 8'h01);
            h.rd(8'hdc, q);
            chk(q, gexp(4'h1 << g, p));
            h.rd(8'hdc, q);
            chk(q, gexp(4'h0, p));
        end
        // Reset in mid-run clears enables, flags and the request
        h.wr(8'h4c, 8'h00);
        h.wr(8'hd9, 8'h01);
        ev[5][0] = 1;
        @(negedge clock);
        ev[5][0] = 0;
        arst_n = 0;
        @(negedge clock);
        chk({7'h0, irq}, 8'h00);
        arst_n = 1;
        h.rd(8'hdb, q);
        chk(q, 8'h00);
        h.rd(8'hd9, q);
        chk(q, 8'h00);
        repeat (2) @(negedge clock);
        chk({7'h0, irq}, 8'h00);
        test_done();
    end
endmodule
